// file: hw/pwm_timing_pkg.sv
package pwm_timing_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] PERIOD_OFS      = 8'h04;
    localparam logic [7:0] SAMPLE_OFS      = 8'h08;
    localparam logic [7:0] EDGE_A_OFS      = 8'h0C;
    localparam logic [7:0] EDGE_B_OFS      = 8'h10;
    localparam logic [7:0] BLANK_OFS       = 8'h14;
    localparam logic [7:0] WINDOW_OFS      = 8'h18;
    localparam logic [7:0] TARGET_OFS      = 8'h1C;
    localparam logic [7:0] LIMIT_OFS       = 8'h20;
    localparam logic [7:0] ACC_A_OFS       = 8'h24;
    localparam logic [7:0] ACC_B_OFS       = 8'h28;
    localparam logic [7:0] MEASURE_OFS     = 8'h2C;

    // widths
    localparam int COARSE_W  = 14;
    localparam int FINE_W    = 4;
    localparam int EDGE_W    = COARSE_W + FINE_W;
    localparam int TIME_W    = 8;
    localparam int ACC_W     = 16;

    // fine phase count and finest step
    localparam int FINE_PHASES    = 16;
    localparam int FINE_STEP_PS   = 250;
    localparam int FINE_COARSE_PS = FINE_STEP_PS * FINE_PHASES;

    // counting clock is a quarter of clk
    localparam int TICK_DIV = 4;

    // reset values
    localparam logic [COARSE_W-1:0] PERIOD_RST = 14'h0FA0;
    localparam logic [COARSE_W-1:0] SAMPLE_RST = 14'h0000;
    localparam logic [EDGE_W-1:0]   EDGE_A_RST = 18'h07D00;
    localparam logic [EDGE_W-1:0]   EDGE_B_RST = 18'h0F900;
    localparam logic [TIME_W-1:0]   BLANK_RST  = 8'h02;
    localparam logic [TIME_W-1:0]   WINDOW_RST = 8'h10;
    localparam logic [TIME_W-1:0]   TARGET_RST = 8'h02;
    localparam logic [ACC_W-1:0]    LIMIT_RST  = 16'h0040;
    localparam logic [ACC_W-1:0]    ACC_RST    = 16'h0000;

    // oversampling encodings
    localparam logic [1:0] OS_1X = 2'h0;
    localparam logic [1:0] OS_2X = 2'h1;
    localparam logic [1:0] OS_4X = 2'h2;
    localparam logic [1:0] OS_8X = 2'h3;

    // control register layout
    typedef struct packed {
        logic       manual_mode;     // bit 12
        logic [3:0] irq_divide;      // bits 11:8
        logic [1:0] oversample;      // bits 7:6
        logic [2:0] fine_edge_step_scale; // bits 5:3
        logic       fine_edge_multi_output_enable; // bit 2
        logic       fine_enable;     // bit 1
        logic       run;             // bit 0
    } ctrl_s;

    localparam int CTRL_W = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

    // dead-time channel settings
    typedef struct packed {
        logic [TIME_W-1:0] blank;
        logic [TIME_W-1:0] window;
        logic [TIME_W-1:0] target;
        logic [ACC_W-1:0]  limit;
        logic              manual_mode;
    } dt_cfg_s;

endpackage : pwm_timing_pkg

// file: hw/deadtime_channel.sv
`timescale 1ns/100ps
`default_nettype none

module deadtime_channel
    import pwm_timing_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire dt_cfg_s           cfg,
    input  wire logic              pwm_level,
    input  wire logic              sense,
    input  wire logic              acc_write,
    input  wire logic [ACC_W-1:0]  acc_wdata,
    output logic [ACC_W-1:0]       accumulator,
    output logic [TIME_W-1:0]      measured
);

    typedef enum {IDLE, BLANK, WINDOW} dt_state_e;

    dt_state_e         state;
    logic              pwm_prev;
    logic [TIME_W-1:0] timer;
    logic [TIME_W-1:0] capture;
    logic              done;
    logic signed [ACC_W-1:0] delta;
    logic signed [ACC_W:0]   sum;
    logic signed [ACC_W-1:0] lim;

    // falling edge opens the blank then the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= IDLE;
            pwm_prev <= 1'b0;
            timer    <= '0;
            capture  <= '0;
            done     <= 1'b0;
        end else begin
            pwm_prev <= pwm_level;
            done     <= 1'b0;
            case (state)
                IDLE: begin
                    if (pwm_prev && !pwm_level) begin // see [RULE10]
                        state   <= BLANK;
                        timer   <= cfg.blank;
                        capture <= '0;
                    end
                end
                BLANK: begin
                    if (timer == '0) begin // see [RULE11]
                        state <= WINDOW;
                        timer <= cfg.window;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                WINDOW: begin
                    if (sense && capture != '1) begin
                        capture <= capture + 1'b1; // see [RULE12]
                    end
                    if (timer <= 1) begin // see [RULE11]
                        state <= IDLE;
                        done  <= 1'b1;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // delta from conduction beyond target, clamped sum
    always_comb begin
        delta = $signed({{(ACC_W-TIME_W){1'b0}}, capture})
              - $signed({{(ACC_W-TIME_W){1'b0}}, cfg.target}); // see [RULE15]
        sum   = $signed({accumulator[ACC_W-1], accumulator}) +
                $signed({delta[ACC_W-1], delta});
        lim   = $signed(cfg.limit);
    end

    // accumulator update once per cycle or by firmware
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= ACC_RST; // see [RULE14]
            measured    <= '0;
        end else begin
            if (done) begin
                measured <= capture;
            end
            if (cfg.manual_mode) begin
                if (acc_write) begin
                    accumulator <= acc_wdata; // see [RULE16]
                end
            end else if (done) begin
                if (sum > $signed({lim[ACC_W-1], lim})) begin
                    accumulator <= lim; // see [RULE16]
                end else if (sum < -$signed({lim[ACC_W-1], lim})) begin
                    accumulator <= -lim;
                end else begin
                    accumulator <= sum[ACC_W-1:0]; // see [RULE15]
                end
            end
        end
    end

endmodule : deadtime_channel

`default_nettype wire

// file: hw/hires_pwm_timing.sv
// Overview of operation
// [RULE1] sixteen phases give fine edges, sixteen times the counting tick
// [RULE2] fine section switchable, step scale from 4 ns to 250 ps
// [RULE3] oversample 00 gives one error ADC trigger per period
// [RULE4] oversample 01, 10, 11 give two, four, eight triggers
// [RULE5] extra triggers spaced by period divided by the factor
// [RULE6] period interrupt base rate equals switching frequency
// [RULE7] interrupt passes a divider reaching 255
// [RULE8] divided interrupt also starts general purpose ADC sequence
// [RULE9] divide settings 1..15 map to fixed counts, fire every count+1
// [RULE10] blank opens right after each rectifier output falling edge, then the window
// [RULE11] window starts after blank delay and lasts programmed length
// [RULE12] capture timer counts conduction input active time in window
// [RULE13] measured conduction shifts next cycle turn-off edge
// [RULE14] accumulators A and B are signed and reset to zero
// [RULE15] each cycle delta from conduction added, sum sets dead time
// [RULE16] auto mode clamps against thresholds, manual lets firmware write
// [RULE17] driver supplies one conduction sense per rectifier output
// [RULE18] low four edge bits pick phase, upper fourteen count ticks
// [RULE19] error ADC trigger when period counter equals sample count
// [RULE20] divider counts periods, pulses at count, restarts from zero
`timescale 1ns/100ps
`default_nettype none

module hires_pwm_timing
    import pwm_timing_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             conduction_sense_in_0,
    input  wire logic             conduction_sense_in_1,
    output logic                  rectifier_pwm_out_0,
    output logic                  rectifier_pwm_out_1,
    output logic [FINE_W-1:0]     fine_phase_0,
    output logic [FINE_W-1:0]     fine_phase_1,
    output logic                  error_adc_trigger,
    output logic                  period_irq,
    output logic                  general_purpose_adc_start
);

    logic                 rst_meta;
    logic                 rst_n;
    ctrl_s                ctrl;
    logic [COARSE_W-1:0]  period;
    logic [COARSE_W-1:0]  sample_count;
    logic [EDGE_W-1:0]    edge_a;
    logic [EDGE_W-1:0]    edge_b;
    logic [TIME_W-1:0]    blank;
    logic [TIME_W-1:0]    window;
    logic [TIME_W-1:0]    target;
    logic [ACC_W-1:0]     limit;
    dt_cfg_s              dt_cfg;
    logic [1:0]           tick_div;
    logic                 tick;
    logic [COARSE_W-1:0]  count;
    logic                 period_end;
    logic [COARSE_W-1:0]  seg_len;
    logic [COARSE_W-1:0]  seg_count;
    logic [3:0]           extra_left;
    logic [3:0]           extra_total;
    logic [7:0]           div_count;
    logic [7:0]           div_target;
    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_hit;
    logic [1:0]           acc_write;
    logic [1:0][ACC_W-1:0]  acc;
    logic [1:0][TIME_W-1:0] meas;
    logic [1:0]           sense;
    logic [1:0]           pwm_lvl;
    logic [1:0][EDGE_W-1:0] edge_raw;
    logic [1:0][COARSE_W-1:0] fall_at;
    logic [FINE_W-1:0]    fine_mask;
    logic [COARSE_W-1:0]  half_period;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // apb decode, zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    always_comb begin
        case (paddr)
            CTRL_OFS, PERIOD_OFS, SAMPLE_OFS, EDGE_A_OFS, EDGE_B_OFS,
            BLANK_OFS, WINDOW_OFS, TARGET_OFS, LIMIT_OFS, ACC_A_OFS,
            ACC_B_OFS, MEASURE_OFS: addr_hit = 1'b1;
            default:                addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_hit;

    // register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl         <= CTRL_RST;
            period       <= PERIOD_RST;
            sample_count <= SAMPLE_RST;
            edge_a       <= EDGE_A_RST;
            edge_b       <= EDGE_B_RST;
            blank        <= BLANK_RST;
            window       <= WINDOW_RST;
            target       <= TARGET_RST;
            limit        <= LIMIT_RST;
        end else if (wr_en) begin
            case (paddr)
                CTRL_OFS:   ctrl         <= pwdata[CTRL_W-1:0];
                PERIOD_OFS: period       <= pwdata[COARSE_W-1:0];
                SAMPLE_OFS: sample_count <= pwdata[COARSE_W-1:0];
                EDGE_A_OFS: edge_a       <= pwdata[EDGE_W-1:0];
                EDGE_B_OFS: edge_b       <= pwdata[EDGE_W-1:0];
                BLANK_OFS:  blank        <= pwdata[TIME_W-1:0];
                WINDOW_OFS: window       <= pwdata[TIME_W-1:0];
                TARGET_OFS: target       <= pwdata[TIME_W-1:0];
                LIMIT_OFS:  limit        <= pwdata[ACC_W-1:0];
                default:    ;
            endcase
        end
    end

    // firmware accumulator writes, used in manual mode
    assign acc_write[0] = wr_en && (paddr == ACC_A_OFS);
    assign acc_write[1] = wr_en && (paddr == ACC_B_OFS);

    // read data register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                CTRL_OFS:    prdata <= {19'h00000, ctrl};
                PERIOD_OFS:  prdata <= {18'h00000, period};
                SAMPLE_OFS:  prdata <= {18'h00000, sample_count};
                EDGE_A_OFS:  prdata <= {14'h0000, edge_a};
                EDGE_B_OFS:  prdata <= {14'h0000, edge_b};
                BLANK_OFS:   prdata <= {24'h000000, blank};
                WINDOW_OFS:  prdata <= {24'h000000, window};
                TARGET_OFS:  prdata <= {24'h000000, target};
                LIMIT_OFS:   prdata <= {16'h0000, limit};
                ACC_A_OFS:   prdata <= {{16{acc[0][ACC_W-1]}}, acc[0]};
                ACC_B_OFS:   prdata <= {{16{acc[1][ACC_W-1]}}, acc[1]};
                MEASURE_OFS: prdata <= {16'h0000, meas[1], meas[0]};
                default:     prdata <= 32'h00000000;
            endcase
        end
    end

    // quarter-rate counting tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_div <= 2'h0;
        end else begin
            tick_div <= tick_div + 2'h1;
        end
    end
    assign tick = ctrl.run && (tick_div == 2'(TICK_DIV - 1));

    // period counter
    assign period_end = tick && (count >= period);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!ctrl.run) begin
            count <= '0;
        end else if (period_end) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    // oversample spacing and count of extra triggers
    always_comb begin
        case (ctrl.oversample)
            OS_2X:   extra_total = 4'h1; // see [RULE4]
            OS_4X:   extra_total = 4'h3;
            OS_8X:   extra_total = 4'h7;
            default: extra_total = 4'h0; // see [RULE3]
        endcase
        seg_len = period >> ctrl.oversample; // see [RULE5]
    end

    // error adc trigger at sample count, extras every segment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            error_adc_trigger <= 1'b0;
            seg_count         <= '0;
            extra_left        <= 4'h0;
        end else begin
            error_adc_trigger <= 1'b0;
            if (tick && count == sample_count) begin
                error_adc_trigger <= 1'b1; // see [RULE19]
                extra_left        <= extra_total;
                seg_count         <= 14'h0001;
            end else if (tick && extra_left != 4'h0) begin
                if (seg_count >= seg_len) begin
                    error_adc_trigger <= 1'b1; // see [RULE5]
                    extra_left        <= extra_left - 4'h1;
                    seg_count         <= 14'h0001;
                end else begin
                    seg_count <= seg_count + 1'b1;
                end
            end
        end
    end

    // divide setting to divide count
    always_comb begin
        case (ctrl.irq_divide)
            4'h1:    div_target = 8'h00; // see [RULE9]
            4'h2:    div_target = 8'h01;
            4'h3:    div_target = 8'h03;
            4'h4:    div_target = 8'h07;
            4'h5:    div_target = 8'h0F;
            4'h6:    div_target = 8'h1F;
            4'h7:    div_target = 8'h2F;
            4'h8:    div_target = 8'h3F;
            4'h9:    div_target = 8'h4F;
            4'hA:    div_target = 8'h5F;
            4'hB:    div_target = 8'h7F;
            4'hC:    div_target = 8'h9F;
            4'hD:    div_target = 8'hBF;
            4'hE:    div_target = 8'hDF;
            4'hF:    div_target = 8'hFF; // see [RULE7]
            default: div_target = 8'h00;
        endcase
    end

    // period interrupt divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count  <= 8'h00;
            period_irq <= 1'b0;
        end else begin
            period_irq <= 1'b0;
            if (period_end) begin // see [RULE6]
                if (div_count >= div_target) begin
                    period_irq <= 1'b1; // see [RULE20]
                    div_count  <= 8'h00;
                end else begin
                    div_count <= div_count + 8'h01;
                end
            end
        end
    end
    assign general_purpose_adc_start = period_irq; // see [RULE8]

    // turn-off edges moved by the accumulators
    assign edge_raw[0]  = edge_a;
    assign edge_raw[1]  = edge_b;
    assign half_period  = period >> 1;
    assign sense[0]     = conduction_sense_in_0; // see [RULE17]
    assign sense[1]     = conduction_sense_in_1;
    assign dt_cfg       = '{blank: blank, window: window, target: target,
                            limit: limit, manual_mode: ctrl.manual_mode};

    // fine step mask: low scale bits cleared for coarser steps
    always_comb begin
        fine_mask = 4'hF;
        if (ctrl.fine_edge_step_scale >= 3'h4) begin
            fine_mask = 4'h0; // see [RULE2]
        end else begin
            fine_mask = 4'(4'hF << ctrl.fine_edge_step_scale);
        end
    end

    // per rectifier output edge and dead-time loop
    for (genvar i = 0; i < 2; i++) begin : g_out
        // coarse ticks from upper bits, shifted by accumulator
        assign fall_at[i] = COARSE_W'(edge_raw[i][EDGE_W-1:FINE_W]
                          + acc[i][COARSE_W-1:0]); // see [RULE13] [RULE18]

        // output a high from start, b high from half period
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pwm_lvl[i] <= 1'b0;
            end else if (!ctrl.run) begin
                pwm_lvl[i] <= 1'b0;
            end else if (tick) begin
                if (count == fall_at[i]) begin
                    pwm_lvl[i] <= 1'b0;
                end else if (count == ((i == 0) ? '0 : half_period)) begin
                    pwm_lvl[i] <= 1'b1;
                end
            end
        end

        deadtime_channel u_dt (
            .clk         (clk),
            .rst_n       (rst_n),
            .cfg         (dt_cfg),
            .pwm_level   (pwm_lvl[i]),
            .sense       (sense[i]),
            .acc_write   (acc_write[i]),
            .acc_wdata   (pwdata[ACC_W-1:0]),
            .accumulator (acc[i]),
            .measured    (meas[i])
        );
    end

    // fine phase select for the sixteen-phase edge stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_phase_0 <= 4'h0;
            fine_phase_1 <= 4'h0;
        end else begin
            fine_phase_0 <= ctrl.fine_enable ?
                            (edge_a[FINE_W-1:0] & fine_mask) : 4'h0; // see [RULE1] [RULE18]
            fine_phase_1 <= (ctrl.fine_enable &&
                             ctrl.fine_edge_multi_output_enable) ?
                            (edge_b[FINE_W-1:0] & fine_mask) : 4'h0; // see [RULE2]
        end
    end

    // registered waveform outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rectifier_pwm_out_0 <= 1'b0;
            rectifier_pwm_out_1 <= 1'b0;
        end else begin
            rectifier_pwm_out_0 <= pwm_lvl[0];
            rectifier_pwm_out_1 <= pwm_lvl[1];
        end
    end

endmodule : hires_pwm_timing

`default_nettype wire

// file: test/pwm_props.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_props (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        error_adc_trigger,
    input wire logic        period_irq,
    input wire logic        general_purpose_adc_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // pulses are one tick apart at the least
    sequence s_trig_gap; !error_adc_trigger [*3]; endsequence
    sequence s_irq_gap; !period_irq [*3]; endsequence
    property p_trig; error_adc_trigger |=> s_trig_gap; endproperty
    property p_irq; period_irq |=> s_irq_gap; endproperty
    property p_gp; general_purpose_adc_start == period_irq; endproperty
    // bus answer
    property p_ready; pready; endproperty
    property p_bad; psel && penable && paddr > 8'h2C |-> pslverr; endproperty
    property p_good;
        psel && penable && paddr <= 8'h2C && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    property p_idle; !(psel && penable) |-> !pslverr; endproperty
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_trig: assert property (p_trig)
        else $error("sample triggers too close");
    a_irq: assert property (p_irq)
        else $error("period pulses too close");
    a_gp: assert property (p_gp)
        else $error("adc start differs from period pulse");
    a_ready: assert property (p_ready) else $error("pready low");
    a_bad: assert property (p_bad) else $error("no error on unmapped");
    a_good: assert property (p_good) else $error("error on mapped");
    a_idle: assert property (p_idle) else $error("error outside access");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule : pwm_props
bind hires_pwm_timing pwm_props ck_u (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .error_adc_trigger(error_adc_trigger), .period_irq(period_irq),
    .general_purpose_adc_start(general_purpose_adc_start));
`default_nettype wire

// file: test/sr_driver_model.sv
`timescale 1ns/100ps
`default_nettype none
module sr_driver_model #(
    parameter int HOLD = 20
) (
    input  wire logic clk,
    input  wire logic pwm_0,
    input  wire logic pwm_1,
    output logic      sense_0,
    output logic      sense_1
);
    int   left_0 = 0;
    int   left_1 = 0;
    logic last_0 = 1'b0;
    logic last_1 = 1'b0;
    // one sense line per output, high for a while after each fall
    always @(posedge clk) begin
        last_0 <= pwm_0;
        last_1 <= pwm_1;
        left_0 <= (last_0 && !pwm_0) ? HOLD : (left_0 > 0 ? left_0 - 1 : 0);
        left_1 <= (last_1 && !pwm_1) ? HOLD : (left_1 > 0 ? left_1 - 1 : 0);
    end
    assign sense_0 = left_0 > 0;
    assign sense_1 = left_1 > 0;
endmodule : sr_driver_model
`default_nettype wire

// file: test/hires_pwm_sampling_deadtime_adjust_test.sv
`timescale 1ns/100ps
`default_nettype none
module hires_pwm_sampling_deadtime_adjust_test import pwm_timing_pkg::*;;
    logic              clk = 1'b0, arst_n = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata, q;
    logic              pready, pslverr, e, s0, s1, o0, o1, trig, irq, gp;
    logic [FINE_W-1:0] ph0, ph1;
    int                failures = 0, n_tests = 0;
    localparam logic [7:0] DIV_CNT [1:15] = '{8'h00, 8'h01, 8'h03, 8'h07,
        8'h0F, 8'h1F, 8'h2F, 8'h3F, 8'h4F, 8'h5F, 8'h7F, 8'h9F, 8'hBF,
        8'hDF, 8'hFF};
    always #5 clk = ~clk;
    hires_pwm_timing dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conduction_sense_in_0(s0), .conduction_sense_in_1(s1),
        .rectifier_pwm_out_0(o0), .rectifier_pwm_out_1(o1),
        .fine_phase_0(ph0), .fine_phase_1(ph1), .error_adc_trigger(trig),
        .period_irq(irq), .general_purpose_adc_start(gp));
    sr_driver_model #(.HOLD(20)) drv_u (.clk(clk), .pwm_0(o0), .pwm_1(o1),
        .sense_0(s0), .sense_1(s1));
    // verdict and end of run
    task test_done;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bail(input logic c);
        if (c) begin
            failures++;
            test_done();
        end
    endtask : bail
    // one apb transfer, read data and error kept in q and e
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        bail(pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // cycles up to the next period pulse
    task wait_irq(input int bound, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (irq !== 1'b1 && n < bound);
        bail(irq !== 1'b1);
    endtask : wait_irq
    // length of the next high pulse on output 0
    task high_width(output int n);
        int i;
        i = 0;
        while (o0 !== 1'b0 && i < 200) begin
            @(negedge clk);
            i++;
        end
        while (o0 !== 1'b1 && i < 400) begin
            @(negedge clk);
            i++;
        end
        bail(o0 !== 1'b1);
        n = 0;
        while (o0 === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask : high_width
    task t_registers;
        logic [31:0] exp [12];
        exp = '{32'(CTRL_RST), 32'(PERIOD_RST), 32'(SAMPLE_RST),
            32'(EDGE_A_RST), 32'(EDGE_B_RST), 32'(BLANK_RST), 32'(WINDOW_RST),
            32'(TARGET_RST), 32'(LIMIT_RST), 32'(ACC_RST), 32'(ACC_RST), 32'h0};
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check(q, exp[i]);
        end
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
    endtask : t_registers
    task t_divider;
        int n;
        apb(1'b1, PERIOD_OFS, 32'h3);
        for (int s = 1; s < 16; s++) begin
            apb(1'b1, CTRL_OFS, 32'(s << 8) | 32'h1);
            wait_irq(8300, n);
            wait_irq(8300, n);
            check(n, 16 * (DIV_CNT[s] + 1));
        end
    endtask : t_divider
    task t_oversample;
        int n;
        apb(1'b1, PERIOD_OFS, 32'h10);
        for (int os = 0; os < 4; os++) begin
            apb(1'b1, CTRL_OFS, 32'(os << 6) | 32'h1);
            repeat (68) @(negedge clk);
            n = 0;
            repeat (272) begin
                @(negedge clk);
                n += (trig === 1'b1);
            end
            check(n, 4 << os);
        end
    endtask : t_oversample
    task t_deadtime;
        int w;
        apb(1'b1, EDGE_A_OFS, 32'h4B);
        apb(1'b1, EDGE_B_OFS, 32'hC7);
        apb(1'b1, WINDOW_OFS, 32'h8);
        apb(1'b1, TARGET_OFS, 32'h5);
        apb(1'b1, LIMIT_OFS, 32'h2);
        apb(1'b1, CTRL_OFS, 32'h1001);
        apb(1'b1, ACC_A_OFS, 32'h0);
        apb(1'b1, ACC_B_OFS, 32'h0);
        high_width(w);
        check(w, 16);
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (8) wait_irq(100, w);
        apb(1'b0, ACC_A_OFS, 32'h0);
        check(q, 32'h2);
        apb(1'b0, ACC_B_OFS, 32'h0);
        check(q, 32'h2);
        apb(1'b0, MEASURE_OFS, 32'h0);
        check(q, 32'h0808);
        high_width(w);
        check(w, 24);
        apb(1'b1, ACC_A_OFS, 32'h7);
        apb(1'b0, ACC_A_OFS, 32'h0);
        check(q, 32'h2);
        apb(1'b1, CTRL_OFS, 32'h1000);
        apb(1'b1, ACC_A_OFS, 32'hFFFE);
        apb(1'b0, ACC_A_OFS, 32'h0);
        check(q, 32'hFFFFFFFE);
        check(32'({ph1, ph0}), 32'h0);
        apb(1'b1, CTRL_OFS, 32'hE);
        repeat (2) @(negedge clk);
        check(32'({ph1, ph0}), 32'h6A);
    endtask : t_deadtime
    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_registers();
        t_divider();
        t_oversample();
        t_deadtime();
        test_done();
    end
endmodule : hires_pwm_sampling_deadtime_adjust_test
`default_nettype wire
